// >>> rtl/dspx_exec.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RL1: a:b is one 96-bit unsigned product
// RL2: program clears a before first step
// RL3: one step per opcode; N steps
// RL4: add r when b[0]; shift into a
// RL5: b shifts right, gets sum bit zero
// RL6: multiply step leaves r unchanged
// RL7: nop changes no register or flag
// RL8: startup op: clr54 clr55 set55 set54 set54
// RL9: pointer load takes 6-bit immediate
// RL10: indirect pointer from RAM 44/45
// RL11: not inverts accumulator, updates COSZ
// RL12: or merges two accumulators, updates COSZ
module dspx_exec #(
    parameter int unsigned W = dspx_pkg::WORD_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic op_valid,
    input wire dspx_pkg::dspx_op_e op,
    input wire dspx_pkg::dspx_acc_e op_p1,
    input wire dspx_pkg::dspx_acc_e op_p2,
    input wire logic [5:0] op_imm,
    output logic op_ready,
    input wire logic [5:0] ram_rdata,
    output logic [5:0] ram_raddr,
    output logic [W-1:0] acc_a,
    output logic [W-1:0] acc_b,
    output logic [W-1:0] acc_r,
    output logic [5:0] ram_ptr,
    output logic flag_c,
    output logic flag_o,
    output logic flag_s,
    output logic flag_z,
    output logic bit_valid,
    output logic bit_set,
    output logic [5:0] bit_index
);
    logic [W-1:0] a_q, b_q, r_q;
    logic [5:0] ptr_q;
    logic c_q, o_q, s_q, z_q;
    logic seq_busy, seq_start;
    logic [W-1:0] sum;
    logic [W-1:0] sel1, sel2, logic_res;
    logic [W-1:0] b_next_mul, a_next_mul;
    logic do_op;

    dspx_bit_if bus ();

    function automatic logic [W-1:0] pick(input dspx_pkg::dspx_acc_e s, input logic [W-1:0] a,
                                          input logic [W-1:0] b, input logic [W-1:0] r);
        case (s)
            dspx_pkg::DSPX_ACC_A: pick = a;
            dspx_pkg::DSPX_ACC_B: pick = b;
            default: pick = r;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////
    // Decode; the startup sequence holds off new opcodes while it runs
    assign op_ready = !seq_busy;
    assign do_op = op_valid && op_ready;
    assign seq_start = do_op && op == dspx_pkg::DSPX_OP_STARTUP;

    // RL10: indirect pointer address select
    assign ram_raddr = (op == dspx_pkg::DSPX_OP_RAD_DP1) ? dspx_pkg::DATA_POINTER_ONE_ADDR :
                       dspx_pkg::DATA_POINTER_ZERO_ADDR;

    // RL1: a:b times r, one bit
    // Carry out is dropped: a's top bit is forced to zero after each step
    assign sum = a_q + (b_q[0] ? r_q : {W{1'b0}});
    // RL4: shifted sum, top bit zero
    assign a_next_mul = {1'b0, sum[W-1:1]};
    // RL5: b gets sum bit zero
    assign b_next_mul = {sum[0], b_q[W-1:1]};

    assign sel1 = pick(op_p1, a_q, b_q, r_q);
    assign sel2 = pick(op_p2, a_q, b_q, r_q);
    assign logic_res = (op == dspx_pkg::DSPX_OP_NOT) ? ~sel1 : (sel1 | sel2);

    ////////////////////////////////////////////////////////////////
    // Accumulators
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            a_q <= '0;
            b_q <= '0;
            r_q <= '0;
        end else if (do_op) begin
            case (op)
                // RL3: exactly one step per opcode
                dspx_pkg::DSPX_OP_MULT: begin
                    a_q <= a_next_mul;
                    b_q <= b_next_mul;
                end
                // RL11: one's complement; RL12: OR into p1
                dspx_pkg::DSPX_OP_NOT, dspx_pkg::DSPX_OP_OR: begin
                    if (op == dspx_pkg::DSPX_OP_NOT || op_p1 != op_p2) begin
                        case (op_p1)
                            dspx_pkg::DSPX_ACC_A: a_q <= logic_res;
                            dspx_pkg::DSPX_ACC_B: b_q <= logic_res;
                            default: r_q <= logic_res;
                        endcase
                    end
                end
                // RL7: nop leaves everything
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // Flags
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            c_q <= 1'b0;
            o_q <= 1'b0;
            s_q <= 1'b0;
            z_q <= 1'b0;
        end else if (do_op) begin
            case (op)
                dspx_pkg::DSPX_OP_MULT: begin
                    s_q <= a_next_mul[W-1];
                    z_q <= ~|{a_next_mul, b_next_mul};
                end
                // RL11: flags from result
                dspx_pkg::DSPX_OP_NOT, dspx_pkg::DSPX_OP_OR: begin
                    c_q <= 1'b0;
                    o_q <= 1'b0;
                    s_q <= logic_res[W-1];
                    z_q <= ~|logic_res;
                end
                // RL8: startup op touches sign and zero
                dspx_pkg::DSPX_OP_STARTUP: begin
                    s_q <= 1'b0;
                    z_q <= 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // RAM pointer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ptr_q <= 6'h00;
        end else if (do_op) begin
            case (op)
                // RL9: direct load
                dspx_pkg::DSPX_OP_RAD: ptr_q <= op_imm;
                // RL10: through data pointer
                dspx_pkg::DSPX_OP_RAD_DP0, dspx_pkg::DSPX_OP_RAD_DP1: ptr_q <= ram_rdata;
                default: begin
                end
            endcase
        end
    end

    dspx_startup_seq u_seq (
        .clk(clk),
        .rst(rst),
        .start(seq_start),
        .busy(seq_busy),
        .bit_op(bus.src)
    );

    assign bit_valid = bus.valid;
    assign bit_set = bus.set;
    assign bit_index = bus.index;
    assign acc_a = a_q;
    assign acc_b = b_q;
    assign acc_r = r_q;
    assign ram_ptr = ptr_q;
    assign flag_c = c_q;
    assign flag_o = o_q;
    assign flag_s = s_q;
    assign flag_z = z_q;

    ////////////////////////////////////////////////////////////////
    sequence mult_taken;
        do_op && op == dspx_pkg::DSPX_OP_MULT;
    endsequence

    AST_MULT_A: assert property (@(posedge clk) disable iff (rst)
        mult_taken |=> a_q == (($past(a_q) + ($past(b_q[0]) ? $past(r_q) : '0)) >> 1)) // RL4
        else $error("multiply step a wrong");
    AST_MULT_B: assert property (@(posedge clk) disable iff (rst)
        mult_taken |=> b_q[W-2:0] == $past(b_q[W-1:1]) && b_q[W-1] == ($past(a_q[0]) ^ ($past(b_q[0]) & $past(r_q[0])))) // RL5
        else $error("multiply step b wrong");
    AST_MULT_R: assert property (@(posedge clk) disable iff (rst)
        mult_taken |=> $stable(r_q) && a_q[W-1] == 1'b0) // RL6
        else $error("multiply step touched r");
    AST_MULT_96: assert property (@(posedge clk) disable iff (rst)
        mult_taken |=> {a_q[W-2:0], b_q} == (2*W-1)'(({$past(a_q), $past(b_q)} >> 1)
        + (($past(b_q[0]) ? {1'b0, $past(r_q)} : '0) << (W-1)))) // RL1
        else $error("96-bit step wrong");
    AST_MULT_ONE: assert property (@(posedge clk) disable iff (rst)
        (mult_taken ##1 !do_op) |=> $stable(a_q) && $stable(b_q)) // RL3
        else $error("more than one step");
    AST_NOP: assert property (@(posedge clk) disable iff (rst)
        (do_op && op == dspx_pkg::DSPX_OP_NOP) |=> $stable({a_q, b_q, r_q, ptr_q, c_q, o_q, s_q, z_q})) // RL7
        else $error("nop changed state");
    AST_RAD: assert property (@(posedge clk) disable iff (rst)
        (do_op && op == dspx_pkg::DSPX_OP_RAD) |=> ptr_q == $past(op_imm)) // RL9
        else $error("pointer load wrong");
    AST_RAD_IND: assert property (@(posedge clk) disable iff (rst)
        (do_op && op == dspx_pkg::DSPX_OP_RAD_DP1) |-> ram_raddr == 6'h2D ##1 ptr_q == $past(ram_rdata)) // RL10
        else $error("indirect pointer wrong");
    AST_NOT: assert property (@(posedge clk) disable iff (rst)
        (do_op && op == dspx_pkg::DSPX_OP_NOT && op_p1 == dspx_pkg::DSPX_ACC_R) |=> r_q == ~$past(r_q) && z_q == (r_q == '0)) // RL11
        else $error("invert wrong");
    AST_OR: assert property (@(posedge clk) disable iff (rst)
        (do_op && op == dspx_pkg::DSPX_OP_OR && op_p1 == dspx_pkg::DSPX_ACC_A && op_p2 == dspx_pkg::DSPX_ACC_B)
        |=> a_q == ($past(a_q) | $past(b_q)) && s_q == a_q[W-1]) // RL12
        else $error("or wrong");
    AST_STARTUP_HOLD: assert property (@(posedge clk) disable iff (rst)
        seq_start |=> !op_ready [*5] ##1 op_ready) // RL8
        else $error("startup busy length wrong");
endmodule
`default_nettype wire

// >>> rtl/dspx_startup_seq.sv
`timescale 1ns/1ps
`default_nettype none
module dspx_startup_seq (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    output logic busy,
    dspx_bit_if.src bit_op
);
    logic [2:0] step_q;
    logic run_q;

    // RL8: fixed five step order
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_q <= 1'b0;
            step_q <= 3'h0;
        end else if (run_q) begin
            if (step_q == 3'(dspx_pkg::STARTUP_STEPS - 1)) begin
                run_q <= 1'b0;
                step_q <= 3'h0;
            end else begin
                step_q <= step_q + 3'h1;
            end
        end else if (start) begin
            run_q <= 1'b1;
            step_q <= 3'h0;
        end
    end

    assign busy = run_q;
    assign bit_op.valid = run_q;
    assign bit_op.set = (step_q >= 3'h2);
    assign bit_op.index = (step_q == 3'h1 || step_q == 3'h2) ? dspx_pkg::STARTUP_BIT_HI : dspx_pkg::STARTUP_BIT_LO;

    AST_STARTUP_ORDER: assert property (@(posedge clk) disable iff (rst)
        (start && !run_q) |=> (bit_op.valid && !bit_op.set && bit_op.index == 6'h36)
        ##1 (!bit_op.set && bit_op.index == 6'h37) ##1 (bit_op.set && bit_op.index == 6'h37)
        ##1 (bit_op.set && bit_op.index == 6'h36) [*2] ##1 !bit_op.valid) // RL8
        else $error("startup sequence order wrong");
endmodule
`default_nettype wire

// >>> shared/dspx_bit_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dspx_bit_if;
    logic valid;
    logic set;
    logic [5:0] index;
    modport src (output valid, output set, output index);
    modport dst (input valid, input set, input index);
endinterface
`default_nettype wire

// >>> shared/dspx_pkg.sv
package dspx_pkg;
    localparam int unsigned WORD_W = 48;
    localparam int unsigned RAM_AW = 6;
    localparam int unsigned BIT_AW = 6;
    localparam logic [5:0] DATA_POINTER_ZERO_ADDR = 6'h2C;
    localparam logic [5:0] DATA_POINTER_ONE_ADDR = 6'h2D;
    localparam logic [5:0] STARTUP_BIT_LO = 6'h36;
    localparam logic [5:0] STARTUP_BIT_HI = 6'h37;
    localparam int unsigned STARTUP_STEPS = 5;

    typedef enum logic [3:0] {
        DSPX_OP_NOP,
        DSPX_OP_MULT,
        DSPX_OP_NOT,
        DSPX_OP_OR,
        DSPX_OP_STARTUP,
        DSPX_OP_RAD,
        DSPX_OP_RAD_DP0,
        DSPX_OP_RAD_DP1
    } dspx_op_e;

    typedef enum logic [1:0] {
        DSPX_ACC_A,
        DSPX_ACC_B,
        DSPX_ACC_R
    } dspx_acc_e;
endpackage

// >>> tb/dspx_ram_model.sv
`timescale 1ns/1ps
`default_nettype none
module dspx_ram_model #(
    parameter logic [5:0] PTR0 = 6'h15,
    parameter logic [5:0] PTR1 = 6'h2A
) (
    input wire logic [5:0] raddr,
    output logic [5:0] rdata
);
    always_comb begin
        case (raddr)
            dspx_pkg::DATA_POINTER_ZERO_ADDR: rdata = PTR0;
            dspx_pkg::DATA_POINTER_ONE_ADDR: rdata = PTR1;
            // Other words hold the inverted address, so a wrong address shows unless it is 0x15 or 0x2A
            default: rdata = ~raddr;
        endcase
    end
endmodule
`default_nettype wire

// >>> tb/test_dsp_multiply_step_and_misc_ops.sv
`timescale 1ns/1ps
`default_nettype none
module test_dsp_multiply_step_and_misc_ops;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic op_valid = 1'b0;
    dspx_pkg::dspx_op_e op = dspx_pkg::DSPX_OP_NOP;
    dspx_pkg::dspx_acc_e p1 = dspx_pkg::DSPX_ACC_A;
    dspx_pkg::dspx_acc_e p2 = dspx_pkg::DSPX_ACC_B;
    logic [5:0] imm = 6'h00;
    logic op_ready, bit_valid, bit_set, fc, fo, fs, fz;
    logic [5:0] rdata, raddr, ptr, bidx;
    logic [47:0] a, b, r;
    int failures = 0;
    int tests_run = 0;
    always #5 clk = ~clk;
    dspx_exec i_dspx_exec (.clk(clk), .rst(rst), .op_valid(op_valid), .op(op), .op_p1(p1), .op_p2(p2),
        .op_imm(imm), .op_ready(op_ready), .ram_rdata(rdata), .ram_raddr(raddr), .acc_a(a), .acc_b(b),
        .acc_r(r), .ram_ptr(ptr), .flag_c(fc), .flag_o(fo), .flag_s(fs), .flag_z(fz),
        .bit_valid(bit_valid), .bit_set(bit_set), .bit_index(bidx));
    dspx_ram_model i_dspx_ram_model (.raddr(raddr), .rdata(rdata));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("tests_run=%0d failures=%0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic issue(input dspx_pkg::dspx_op_e o, input dspx_pkg::dspx_acc_e x = dspx_pkg::DSPX_ACC_A,
        input dspx_pkg::dspx_acc_e y = dspx_pkg::DSPX_ACC_B, input logic [5:0] v = 6'h00);
        int n;
        n = 0;
        while (op_ready !== 1'b1 && n < 50) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 50) begin
            failures++;
            complete_run();
        end else begin
            @(posedge clk);
            op <= o;
            p1 <= x;
            p2 <= y;
            imm <= v;
            op_valid <= 1'b1;
            @(posedge clk);
            op_valid <= 1'b0;
            #1;
        end
    endtask
    // Reference step: carry out of a plus r is dropped
    function automatic logic [95:0] mstep(input logic [47:0] x, input logic [47:0] y, input logic [47:0] m);
        logic [47:0] s;
        s = x + (y[0] ? m : 48'h0);
        return {1'b0, s[47:1], s[0], y[47:1]};
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_not();
        issue(dspx_pkg::DSPX_OP_NOT, dspx_pkg::DSPX_ACC_B);
        chk(b, 48'hFFFF_FFFF_FFFF);
        chk({fc, fo, fs, fz}, 4'h2);
        issue(dspx_pkg::DSPX_OP_NOT, dspx_pkg::DSPX_ACC_R);
        chk(r, 48'hFFFF_FFFF_FFFF);
        $display("not done");
    endtask
    task automatic t_mult();
        logic [95:0] e;
        logic [95:0] prod;
        // Multiplier without its top bit, so no step carries out of a plus r
        issue(dspx_pkg::DSPX_OP_NOT, dspx_pkg::DSPX_ACC_R);
        chk(r, 48'h0);
        issue(dspx_pkg::DSPX_OP_MULT);
        chk({a, b}, {48'h0, 48'h7FFF_FFFF_FFFF});
        issue(dspx_pkg::DSPX_OP_OR, dspx_pkg::DSPX_ACC_R, dspx_pkg::DSPX_ACC_B);
        chk(r, 48'h7FFF_FFFF_FFFF);
        chk(a, 48'h0);
        e = {48'h0, 48'h7FFF_FFFF_FFFF};
        prod = {48'h0, 48'h7FFF_FFFF_FFFF} * {48'h0, 48'h7FFF_FFFF_FFFF};
        for (int i = 0; i < 49; i++) begin
            e = mstep(e[95:48], e[47:0], 48'h7FFF_FFFF_FFFF);
            issue(dspx_pkg::DSPX_OP_MULT);
            chk({a, b}, e);
            chk(r, 48'h7FFF_FFFF_FFFF);
            if (i == 47) chk({a, b}, prod);
        end
        chk({fs, fz}, {e[95], e == 96'h0});
        $display("mult done");
    endtask
    task automatic t_nop();
        logic [153:0] s;
        s = {a, b, r, ptr, fc, fo, fs, fz};
        issue(dspx_pkg::DSPX_OP_NOP);
        chk(s[153:58], {a, b});
        chk(s[57:0], {r, ptr, fc, fo, fs, fz});
        $display("nop done");
    endtask
    task automatic t_or();
        logic [47:0] x;
        logic [47:0] y;
        x = a | b;
        y = b;
        issue(dspx_pkg::DSPX_OP_OR);
        chk({a, b}, {x, y});
        chk({fc, fo, fs, fz}, {2'b00, x[47], x == 48'h0});
        issue(dspx_pkg::DSPX_OP_OR, dspx_pkg::DSPX_ACC_B, dspx_pkg::DSPX_ACC_B);
        chk({a, b}, {x, y});
        $display("or done");
    endtask
    task automatic t_startup();
        logic [7:0] seq [5] = '{8'hB6, 8'hB7, 8'hF7, 8'hF6, 8'hF6};
        int n;
        n = 0;
        issue(dspx_pkg::DSPX_OP_STARTUP);
        while (bit_valid !== 1'b1 && n < 10) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 10) begin
            failures++;
            complete_run();
        end else begin
            for (int k = 0; k < 5; k++) begin
                chk({bit_valid, bit_set, bidx}, seq[k]);
                chk(op_ready, 1'b0);
                @(posedge clk);
                #1;
            end
            chk({bit_valid, fs, fz}, 3'h1);
            $display("startup done");
        end
    endtask
    task automatic t_rad();
        dspx_pkg::dspx_op_e o [3] = '{dspx_pkg::DSPX_OP_RAD, dspx_pkg::DSPX_OP_RAD_DP0, dspx_pkg::DSPX_OP_RAD_DP1};
        logic [5:0] e [3] = '{6'h3F, 6'h15, 6'h2A};
        for (int k = 0; k < 3; k++) begin
            issue(o[k], dspx_pkg::DSPX_ACC_A, dspx_pkg::DSPX_ACC_B, 6'h3F);
            chk(ptr, e[k]);
        end
        $display("rad done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk({a, b}, 96'h0);
        chk({r, ptr, fc, fo, fs, fz, op_ready, bit_valid}, {48'h0, 6'h0, 4'h0, 2'b10});
        t_not();
        t_mult();
        t_nop();
        t_or();
        t_startup();
        t_rad();
        complete_run();
    end
endmodule
`default_nettype wire
